// [rtl/tci_top.sv]
// Thermocouple input control: scan sequencer, wire-break test, registers
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps

// Notes on behaviour
// - Integration time follows mains frequency switch
// - Scan only the selected number of channels
// - Open input lights LED, sets break flag
// - Test current, over-threshold voltage means break
// - Test pulses continue with signalling off
// - Linearized spans per type J, K, L
// - Degree units, overrange, then overflow
// - Compensation gives zero at 0 degrees
// - Raw word left-justified, flags low
// - Raw limits 2048, 4095, overflow bit 0
module tci_top #(
    parameter int INTEG_50 = tci_pkg::INTEG_50_CYC,
    parameter int INTEG_60 = tci_pkg::INTEG_60_CYC
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire tci_pkg::tci_mode_t mode_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    output logic [1:0] mux_sel_o,
    output logic test_current_o,
    output logic integ_o,
    input wire logic conv_done_i,
    input wire logic signed [tci_pkg::VAL_W-1:0] conv_value_i,
    input wire logic signed [tci_pkg::VAL_W-1:0] term_temp_i,
    input wire logic brk_cmp_i,
    output logic red_led_o,
    output logic irq_o
);
    import tci_pkg::*;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int SYW = $bits(tci_mode_t) + 2 * VAL_W + 2;
    logic [SYW-1:0] sy1_r; // First stage, read only by sy2_r
    logic [SYW-1:0] sy2_r; // Second stage
    tci_mode_t mode; // Synchronised switches
    logic signed [VAL_W-1:0] cval; // Synchronised converter value
    logic signed [VAL_W-1:0] tterm; // Synchronised terminal temp
    logic cdone; // Synchronised conversion done
    logic bcmp; // Synchronised break comparator

    // Switch and converter pins cross two flip-flops before use; bus pins do not
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sy1_r <= '0;
            sy2_r <= '0;
        end else begin
            sy1_r <= {mode_i, conv_value_i, term_temp_i, conv_done_i,
                      brk_cmp_i};
            sy2_r <= sy1_r;
        end
    end

    assign {mode, cval, tterm, cdone, bcmp} = sy2_r;

    // ------------------------------------------------------------
    // Scan sequencer
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        S_IDLE,
        S_TEST,
        S_INTEG,
        S_WAIT
    } tci_state_t;

    tci_state_t st_r, st_nxt; // Sequencer state
    logic [18:0] cnt_r, cnt_nxt; // Phase timer
    logic [1:0] ch_r, ch_nxt; // Channel being converted
    logic brk_smp_r, brk_smp_nxt; // Comparator sample of this pass
    logic store; // One-cycle result capture
    logic run; // Scan enabled by software
    logic [18:0] integ_len; // Integration cycles for the mode

    // Mains switch picks the integration window
    always_comb begin
        if (mode.mains_60) begin
            integ_len = 19'(INTEG_60);
        end else begin
            integ_len = 19'(INTEG_50);
        end
    end

    // Next state of the sequencer
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        ch_nxt = ch_r;
        brk_smp_nxt = brk_smp_r;
        store = 1'b0;
        case (st_r)
            S_IDLE: begin
                // Start a pass on the current channel
                if (run) begin
                    st_nxt = S_TEST;
                    cnt_nxt = 19'(TEST_CYC - 1);
                end
            end
            S_TEST: begin
                // Test current always flows, enable or not
                if (cnt_r == 19'h0) begin
                    brk_smp_nxt = bcmp;
                    st_nxt = S_INTEG;
                    cnt_nxt = integ_len - 19'h1;
                end else begin
                    cnt_nxt = cnt_r - 19'h1;
                end
            end
            S_INTEG: begin
                // Integrate over a whole mains period
                if (cnt_r == 19'h0) begin
                    st_nxt = S_WAIT;
                end else begin
                    cnt_nxt = cnt_r - 19'h1;
                end
            end
            S_WAIT: begin
                // Converter finishes rundown, then step on
                if (cdone) begin
                    store = 1'b1;
                    st_nxt = S_IDLE;
                    if (ch_r >= mode.ch_cnt) begin
                        ch_nxt = 2'h0;
                    end else begin
                        ch_nxt = ch_r + 2'h1;
                    end
                end
            end
            default: begin
                st_nxt = S_IDLE;
            end
        endcase
    end

    // Sequencer registers
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            st_r <= S_IDLE;
            cnt_r <= 19'h0;
            ch_r <= 2'h0;
            brk_smp_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            ch_r <= ch_nxt;
            brk_smp_r <= brk_smp_nxt;
        end
    end

    assign mux_sel_o = ch_r;
    assign test_current_o = (st_r == S_TEST);
    assign integ_o = (st_r == S_INTEG);

    // ------------------------------------------------------------
    // Value correction and formatting
    // ------------------------------------------------------------
    logic signed [VAL_W-1:0] corr; // Value after compensation
    logic [15:0] fword; // Packed result word
    logic fovr; // Overrange class
    logic fovf; // Overflow class
    logic brk_ind; // Break shown to software

    // Compensation only acts on linearized temperatures
    always_comb begin
        if (mode.lin_en && mode.comp_en) begin
            corr = cval + tterm;
        end else begin
            corr = cval;
        end
        brk_ind = brk_smp_r && mode.wb_en;
    end

    // Linearization without compensation is refused by the
    // operator; the block still formats in degrees if it happens.
    tci_format u_fmt (
        .value_i(corr),
        .mode_i(mode),
        .brk_i(brk_ind),
        .word_o(fword),
        .ovr_o(fovr),
        .ovf_o(fovf)
    );

    // ------------------------------------------------------------
    // Result words and per-channel flags
    // ------------------------------------------------------------
    logic [15:0] res_r [NCH]; // Latest word per channel
    logic [15:0] res_nxt [NCH];
    logic [NCH-1:0] brk_r, brk_nxt; // Current break per channel
    logic [NCH-1:0] ovr_r, ovr_nxt; // Current overrange per channel

    genvar gi;
    generate
        for (gi = 0; gi < NCH; gi++) begin : g_ch
            // Update on completion of this channel; unscanned channels clear their break
            always_comb begin
                res_nxt[gi] = res_r[gi];
                brk_nxt[gi] = brk_r[gi];
                ovr_nxt[gi] = ovr_r[gi];
                if (store && ch_r == 2'(gi)) begin
                    res_nxt[gi] = fword;
                    brk_nxt[gi] = brk_ind;
                    ovr_nxt[gi] = fovr;
                end else if (2'(gi) > mode.ch_cnt) begin
                    // Unscanned channels hold no stale fault
                    brk_nxt[gi] = 1'b0;
                end
            end

            // Result registers
            always_ff @(posedge mclk_i or negedge reset_n_i) begin
                if (!reset_n_i) begin
                    res_r[gi] <= 16'h0000;
                    brk_r[gi] <= 1'b0;
                    ovr_r[gi] <= 1'b0;
                end else begin
                    res_r[gi] <= res_nxt[gi];
                    brk_r[gi] <= brk_nxt[gi];
                    ovr_r[gi] <= ovr_nxt[gi];
                end
            end
        end
    endgenerate

    assign red_led_o = |brk_r;

    // ------------------------------------------------------------
    // Register bus and interrupts
    // ------------------------------------------------------------
    tci_bus_t bus; // Bundled bus request
    logic [11:0] stat_r, stat_nxt; // Sticky events
    logic [11:0] ien_r, ien_nxt; // Interrupt enables
    logic [0:0] ctrl_r, ctrl_nxt; // Scan run bit
    logic [31:0] rdata_r, rdata_nxt; // Read data, one cycle later
    logic [11:0] ev; // Events of this cycle

    assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    assign run = ctrl_r[0];

    // Address decode shared by read and write paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        hit = (a == o);
    endfunction

    // Events: done, break, overflow per channel
    always_comb begin
        ev = 12'h000;
        if (store) begin
            ev[ch_r] = 1'b1;
            ev[4 + ch_r] = brk_ind;
            ev[8 + ch_r] = fovf;
        end
    end

    // Register updates; a set beats a clear in the same cycle
    always_comb begin
        stat_nxt = stat_r;
        ien_nxt = ien_r;
        ctrl_nxt = ctrl_r;
        if (bus.wr && hit(bus.addr, OFS_IRQ_CLR)) begin
            stat_nxt = stat_nxt & ~bus.wdata[11:0];
        end
        stat_nxt = stat_nxt | ev;
        if (bus.wr && hit(bus.addr, OFS_IRQ_EN)) begin
            ien_nxt = bus.wdata[11:0];
        end
        if (bus.wr && hit(bus.addr, OFS_CTRL)) begin
            ctrl_nxt = bus.wdata[0:0];
        end
    end

    // Read mux; unmapped and write-only addresses read zero
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (bus.rd) begin
            if (bus.addr[7:4] == 4'h0 && bus.addr[1:0] == 2'h0) begin
                rdata_nxt = {16'h0000, res_r[bus.addr[3:2]]};
            end else if (hit(bus.addr, OFS_STATUS)) begin
                rdata_nxt = {20'h00000, stat_r};
            end else if (hit(bus.addr, OFS_IRQ_EN)) begin
                rdata_nxt = {20'h00000, ien_r};
            end else if (hit(bus.addr, OFS_CTRL)) begin
                rdata_nxt = {31'h0000_0000, ctrl_r};
            end else if (hit(bus.addr, OFS_MODE)) begin
                rdata_nxt = {16'h0000, 4'h0, ovr_r, mode};
            end
        end
    end

    // Bus-side registers
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            stat_r <= 12'h000;
            ien_r <= IRQ_EN_RST;
            ctrl_r <= CTRL_RST;
            rdata_r <= 32'h0000_0000;
        end else begin
            stat_r <= stat_nxt;
            ien_r <= ien_nxt;
            ctrl_r <= ctrl_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign rdata_o = rdata_r;
    assign irq_o = |(stat_r & ien_r);

endmodule

// [pkg/tci_pkg.sv]
// Package: constants, types and register map of the thermocouple input control
package tci_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_KHZ = 20000;           // 20 MHz system clock
    localparam int INTEG_50_US = 20000;       // 20 ms at 50 Hz mains
    localparam int INTEG_60_NS = 16660000;    // 16.66 ms at 60 Hz mains
    localparam int INTEG_50_CYC = INTEG_50_US * (CLK_KHZ / 1000);
    localparam int INTEG_60_CYC = INTEG_60_NS / (1000000 / CLK_KHZ);
    localparam int TEST_US = 50;              // Test-current pulse length
    localparam int TEST_CYC = TEST_US * (CLK_KHZ / 1000);

    // ------------------------------------------------------------
    // Channel and word layout
    // ------------------------------------------------------------
    localparam int NCH = 4;                   // Channels on the module
    localparam int VAL_W = 14;                // Converter value width
    localparam int RAW_NOM = 2048;            // Raw nominal limit
    localparam int RAW_MAX = 4095;            // Raw saturation limit
    localparam int LIN_OVR = 100;             // Overrange band in degrees
    localparam int FLG_OVF_BIT = 0;           // Overflow flag position
    localparam int FLG_BRK_BIT = 1;           // Wire-break flag position
    localparam int VAL_LSB = 3;               // Value starts at bit 3

    // Linearized spans in degrees C
    localparam int J_LO = -200;
    localparam int J_HI = 1200;
    localparam int K_LO = -200;
    localparam int K_HI = 1369;
    localparam int L_LO = -199;
    localparam int L_HI = 900;

    // ------------------------------------------------------------
    // Register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_RESULT0 = 8'h00;  // Results at 0x00..0x0c
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_CLR = 8'h14;
    localparam logic [7:0] OFS_IRQ_EN = 8'h18;
    localparam logic [7:0] OFS_CTRL = 8'h1c;
    localparam logic [7:0] OFS_MODE = 8'h20;
    localparam logic [11:0] IRQ_EN_RST = 12'h000;
    localparam logic [0:0] CTRL_RST = 1'h1;      // Scan runs after reset

    // Thermocouple type selector
    typedef enum logic [1:0] {
        TC_J = 2'h0,
        TC_K = 2'h1,
        TC_L = 2'h2,
        TC_X = 2'h3
    } tci_tc_t;

    // Front-switch settings
    typedef struct packed {
        logic mains_60;       // 1: 60 Hz, 0: 50 Hz
        logic [1:0] ch_cnt;   // Active channels minus one
        logic wb_en;          // Wire-break signalling on
        logic lin_en;         // Linearization on
        logic comp_en;        // Internal compensation on
        tci_tc_t tc_type;     // Thermocouple type
    } tci_mode_t;

    // Register bus request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } tci_bus_t;

endpackage

// [rtl/tci_format.sv]
// Range classification and result-word packing for one conversion
`timescale 1ns/10ps
module tci_format (
    input wire logic signed [tci_pkg::VAL_W-1:0] value_i,
    input wire tci_pkg::tci_mode_t mode_i,
    input wire logic brk_i,
    output logic [15:0] word_o,
    output logic ovr_o,
    output logic ovf_o
);
    import tci_pkg::*;

    // ------------------------------------------------------------
    // Classification
    // ------------------------------------------------------------
    logic signed [VAL_W-1:0] lo; // Nominal low bound
    logic signed [VAL_W-1:0] hi; // Nominal high bound
    logic signed [VAL_W-1:0] sat; // Value after saturation
    logic [12:0] mant; // Sign plus 12 bits

    // Bounds, classes and saturation
    always_comb begin
        lo = -(VAL_W'(RAW_NOM));
        hi = VAL_W'(RAW_NOM);
        ovr_o = 1'b0;
        ovf_o = 1'b0;
        sat = value_i;
        if (mode_i.lin_en) begin
            // One unit per degree; span per type
            case (mode_i.tc_type)
                TC_J: begin
                    lo = VAL_W'(J_LO);
                    hi = VAL_W'(J_HI);
                end
                TC_L: begin
                    lo = VAL_W'(L_LO);
                    hi = VAL_W'(L_HI);
                end
                default: begin
                    lo = VAL_W'(K_LO);
                    hi = VAL_W'(K_HI);
                end
            endcase
            // Just outside is overrange, further out overflow
            if (value_i > hi + VAL_W'(LIN_OVR)) begin
                ovf_o = 1'b1;
                sat = hi + VAL_W'(LIN_OVR);
            end else if (value_i < lo - VAL_W'(LIN_OVR)) begin
                ovf_o = 1'b1;
                sat = lo - VAL_W'(LIN_OVR);
            end else if (value_i > hi || value_i < lo) begin
                ovr_o = 1'b1;
            end
        end else begin
            // Raw millivolt counts, 2048 units per 50 mV
            if (value_i > VAL_W'(RAW_MAX)) begin
                ovf_o = 1'b1;
                sat = VAL_W'(RAW_MAX);
            end else if (value_i < -(VAL_W'(RAW_MAX))) begin
                ovf_o = 1'b1;
                sat = -(VAL_W'(RAW_MAX));
            end else if (value_i > hi || value_i < lo) begin
                ovr_o = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Packing
    // ------------------------------------------------------------
    // Left-justified two's complement, flags in the low bits
    always_comb begin
        mant = sat[12:0];
        word_o = {mant, 3'h0};
        word_o[FLG_OVF_BIT] = ovf_o;
        if (brk_i) begin
            // Value is meaningless on an open input
            word_o = 16'h0000;
            word_o[FLG_BRK_BIT] = 1'b1;
        end
    end

endmodule

// [test/tci_checker.sv]
// Checker for scan phase timing, channel order and bus idle levels
`timescale 1ns/10ps
module tci_checker #(
    parameter int INTEG_50 = 20,
    parameter int INTEG_60 = 16
) (
    input wire logic mclk_i,
    input wire logic reset_n_i,
    input wire tci_pkg::tci_mode_t mode_i,
    input wire logic rd_i,
    input wire logic [31:0] rdata_o,
    input wire logic [1:0] mux_sel_o,
    input wire logic test_current_o,
    input wire logic integ_o,
    input wire logic red_led_o
);
    import tci_pkg::*;
    // ----------------------------------------
    // Phase length counters
    // ----------------------------------------
    logic [31:0] icnt_r; // Cycles of integration so far
    logic [31:0] icnt_nxt;
    logic [31:0] tcnt_r; // Cycles of test current so far
    logic [31:0] tcnt_nxt;
    // Counts clear while the phase is off
    always_comb begin
        icnt_nxt = integ_o ? icnt_r + 32'h1 : 32'h0;
        tcnt_nxt = test_current_o ? tcnt_r + 32'h1 : 32'h0;
    end
    // Registers only
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            icnt_r <= 32'h0;
            tcnt_r <= 32'h0;
        end else begin
            icnt_r <= icnt_nxt;
            tcnt_r <= tcnt_nxt;
        end
    end
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!reset_n_i);
    sequence test_end_s;
        $fell(test_current_o);
    endsequence
    sequence integ_end_s;
        $fell(integ_o);
    endsequence
    phase_excl_a: assert property (!(integ_o && test_current_o))
        else $error("test current during integration");
    integ_len_a: assert property (integ_end_s |->
        icnt_r == 32'(mode_i.mains_60 ? INTEG_60 : INTEG_50))
        else $error("integration length wrong");
    test_len_a: assert property (test_end_s |->
        tcnt_r == 32'(TEST_CYC))
        else $error("test pulse length wrong");
    integ_follow_a: assert property (test_end_s |-> integ_o)
        else $error("integration not after test");
    mux_hold_a: assert property ((integ_o || test_current_o)
        |-> $stable(mux_sel_o))
        else $error("channel moved mid pass");
    mux_step_a: assert property ($changed(mux_sel_o) |->
        (mux_sel_o == 2'h0 || mux_sel_o == $past(mux_sel_o) + 2'h1))
        else $error("channel order broken");
    mux_range_a: assert property ($changed(mux_sel_o) |->
        mux_sel_o <= mode_i.ch_cnt)
        else $error("channel beyond count");
    rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
        else $error("read data without read");
    led_gate_a: assert property ($rose(red_led_o) |-> mode_i.wb_en)
        else $error("fault lamp while signalling off");
endmodule

// [test/tci_conv_model.sv]
// Converter and sensor model facing the scan sequencer
`timescale 1ns/10ps
module tci_conv_model (
    input wire logic mclk_i,
    input wire logic [1:0] mux_sel_i,
    input wire logic test_current_i,
    input wire logic integ_i,
    input wire logic signed [tci_pkg::VAL_W-1:0] val_i [4],
    input wire logic [3:0] open_i,
    input wire logic [7:0] lat_i,
    output logic conv_done_o,
    output logic signed [tci_pkg::VAL_W-1:0] conv_value_o,
    output logic brk_cmp_o
);
    import tci_pkg::*;
    logic integ_q = 1'b0; // Last integration level
    int wait_r = -1; // Cycles until the answer, -1 idle
    initial begin
        conv_done_o = 1'b0;
        conv_value_o = '0;
        brk_cmp_o = 1'b0;
    end
    // Answers a fixed latency after integration ends
    always @(posedge mclk_i) begin
        integ_q <= integ_i;
        // Open input only lifts the voltage while current flows
        brk_cmp_o <= test_current_i & open_i[mux_sel_i];
        if (test_current_i)
            conv_done_o <= 1'b0;
        if (integ_q && !integ_i)
            wait_r <= int'(lat_i);
        else if (wait_r > 0)
            wait_r <= wait_r - 1;
        if (wait_r == 0) begin
            conv_done_o <= 1'b1;
            conv_value_o <= val_i[mux_sel_i];
            wait_r <= -1;
        end else if (!conv_done_o) begin
            // Value not valid yet: keep it moving
            conv_value_o <= ~conv_value_o;
        end
    end
endmodule

// [test/tb_tci_top.sv]
// Testbench for the thermocouple input control
`timescale 1ns/10ps
module tb_tci_top;
    import tci_pkg::*;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam int I50 = 20; // Shortened integration counts
    localparam int I60 = 16;
    localparam int TERM = 25; // Terminal temperature in degrees
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    tci_mode_t mode_i = '0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic signed [VAL_W-1:0] term_temp_i = VAL_W'(TERM);
    logic [31:0] rdata_o;
    logic [1:0] mux_sel_o;
    logic test_current_o;
    logic integ_o;
    logic red_led_o;
    logic irq_o;
    logic conv_done_i;
    logic brk_cmp_i;
    logic signed [VAL_W-1:0] conv_value_i;
    logic signed [VAL_W-1:0] val [4]; // Per-channel sensor values
    logic [3:0] open_ch = 4'h0; // Channels with a broken wire
    logic [7:0] lat = 8'h01; // Converter answer latency
    int failures = 0;
    int check_count = 0;
    tci_mode_t m;
    int n;
    int hi;
    int lv [4];
    logic [1:0] mx;
    int rawv [8] = '{2048, -2048, 5000, -4095, 2049, -5000, 4095, 0};

    always #25 mclk_i = ~mclk_i;

    tci_top #(.INTEG_50(I50), .INTEG_60(I60)) i_tci_top (
        .mclk_i(mclk_i), .reset_n_i(reset_n_i), .mode_i(mode_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .mux_sel_o(mux_sel_o),
        .test_current_o(test_current_o), .integ_o(integ_o),
        .conv_done_i(conv_done_i), .conv_value_i(conv_value_i),
        .term_temp_i(term_temp_i), .brk_cmp_i(brk_cmp_i),
        .red_led_o(red_led_o), .irq_o(irq_o));

    tci_conv_model i_tci_conv_model (
        .mclk_i(mclk_i), .mux_sel_i(mux_sel_o),
        .test_current_i(test_current_o), .integ_i(integ_o),
        .val_i(val), .open_i(open_ch), .lat_i(lat),
        .conv_done_o(conv_done_i), .conv_value_o(conv_value_i),
        .brk_cmp_o(brk_cmp_i));

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask
    // Data stand only in the cycle after the strobe
    task automatic rchk(input logic [7:0] a, input logic [31:0] e,
                        input logic [31:0] msk);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        @(negedge mclk_i);
        chk(rdata_o & msk, e);
    endtask
    task automatic passes(input int k);
        repeat (k) @(posedge test_current_o);
    endtask
    // Mode changes land at the start of the last channel's pass
    task automatic set_mode(input tci_mode_t nm);
        do begin
            @(posedge test_current_o);
        end while (mux_sel_o !== mode_i.ch_cnt);
        @(posedge mclk_i);
        mode_i <= nm;
    endtask
    // Clamp to the limit, flag overflow in bit 0
    function automatic logic [15:0] fmt(input int v, input int lim);
        int q;
        q = (v > lim) ? lim : (v < -lim) ? -lim : v;
        return 16'(q * 8) | {15'h0, v != q};
    endfunction
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        mode_i.ch_cnt = 2'h3;
        mode_i.wb_en = 1'b1;
        mode_i.lin_en = 1'b0;
        repeat (16) @(posedge mclk_i);
        reset_n_i <= 1'b1;
        rchk(OFS_CTRL, 32'h1, 32'h1);
        rchk(OFS_IRQ_EN, 32'h0, 32'hffffffff);
        rchk(OFS_IRQ_CLR, 32'h0, 32'hffffffff);
        rchk(8'h24, 32'h0, 32'hffffffff);
        wr(OFS_MODE, 32'hffffffff);
        rchk(OFS_MODE, 32'(mode_i), 32'hff);
        // Raw words at and beyond each limit, prompt then slow answers
        for (int r = 0; r < 2; r++) begin
            for (int c = 0; c < 4; c++) val[c] = VAL_W'(rawv[r * 4 + c]);
            lat = r ? 8'h28 : 8'h01;
            passes(5);
            for (int c = 0; c < 4; c++) begin
                rchk(OFS_RESULT0 + 8'(4 * c),
                     32'(fmt(rawv[r * 4 + c], RAW_MAX)), 32'hffff);
            end
        end
        rchk(OFS_MODE, 32'h0500, 32'h0f00);
        rchk(OFS_STATUS, 32'h60f, 32'hfff);
        // Interrupt raised, masked, cleared
        wr(OFS_IRQ_EN, 32'h200);
        rchk(OFS_IRQ_EN, 32'h200, 32'hfff);
        chk(32'(irq_o), 32'h1);
        wr(OFS_IRQ_EN, 32'h0);
        rchk(OFS_IRQ_EN, 32'h0, 32'hfff);
        chk(32'(irq_o), 32'h0);
        wr(OFS_IRQ_EN, 32'h200);
        val[1] = '0;
        passes(5);
        wr(OFS_IRQ_CLR, 32'h200);
        rchk(OFS_STATUS, 32'h0, 32'h200);
        chk(32'(irq_o), 32'h0);
        // Broken wire with signalling on, then off
        open_ch = 4'h2;
        passes(5);
        rchk(OFS_RESULT0 + 8'h04, 32'h2, 32'hffff);
        rchk(OFS_STATUS, 32'h20, 32'h20);
        chk(32'(red_led_o), 32'h1);
        m = mode_i;
        m.wb_en = 1'b0;
        set_mode(m);
        passes(5);
        chk(32'(red_led_o), 32'h0);
        rchk(OFS_RESULT0 + 8'h04, 32'h0, 32'hffff);
        open_ch = 4'h0;
        // Mains setting and channel count
        for (int f = 0; f < 2; f++) begin
            m.ch_cnt = 2'(f);
            m.mains_60 = f[0];
            set_mode(m);
            passes(2);
            @(posedge integ_o);
            n = -1;
            while (integ_o === 1'b1) begin
                @(negedge mclk_i);
                n++;
            end
            chk(32'(n), 32'(f ? I60 : I50));
            mx = 2'h0;
            repeat (4) begin
                @(posedge test_current_o);
                if (mux_sel_o > mx)
                    mx = mux_sel_o;
            end
            chk(32'(mx), 32'(f));
        end
        // Linearized spans, one type at a time
        m.ch_cnt = 2'h3;
        m.mains_60 = 1'b0;
        m.lin_en = 1'b1;
        m.comp_en = 1'b1;
        for (int t = 0; t < 3; t++) begin
            hi = (t == 0) ? J_HI : (t == 1) ? K_HI : L_HI;
            m.tc_type = tci_tc_t'(t);
            lv = '{hi, hi + 1, hi + 200, 0};
            for (int c = 0; c < 4; c++) val[c] = VAL_W'(lv[c] - TERM);
            set_mode(m);
            passes(5);
            for (int c = 0; c < 4; c++) begin
                rchk(OFS_RESULT0 + 8'(4 * c),
                     32'(fmt(lv[c], hi + LIN_OVR)), 32'hffff);
            end
            rchk(OFS_MODE, 32'h200, 32'hf00);
        end
        // Scan halts once run is cleared
        wr(OFS_CTRL, 32'h0);
        repeat (1200) @(posedge mclk_i);
        @(negedge mclk_i);
        chk(32'(test_current_o), 32'h0);
        rchk(OFS_CTRL, 32'h0, 32'h1);
        tally_and_finish();
    end

    // Watchdog sized to the full sequence
    initial begin
        #(98000 * 50);
        failures++;
        tally_and_finish();
    end
endmodule

bind tci_top tci_checker #(.INTEG_50(INTEG_50), .INTEG_60(INTEG_60))
    i_tci_checker (
    .mclk_i(mclk_i), .reset_n_i(reset_n_i), .mode_i(mode_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .mux_sel_o(mux_sel_o),
    .test_current_o(test_current_o), .integ_o(integ_o),
    .red_led_o(red_led_o));
